// *** pkg/wrms_cfg.svh ***
`ifndef WRMS_CFG_SVH
`define WRMS_CFG_SVH

// register word addresses
`define WRMS_A_CTRL    4'h0
`define WRMS_A_STATUS  4'h1
`define WRMS_A_TRIG    4'h2
`define WRMS_A_SEQLEN  4'h3
`define WRMS_A_SEL     4'h4
`define WRMS_A_BASE    4'h5
`define WRMS_A_LEN     4'h6
`define WRMS_A_STEP    4'h7
`define WRMS_A_FREQ    4'h8
`define WRMS_A_LEVEL   4'h9

// control register fields
`define WRMS_CTRL_MODE  1:0
`define WRMS_CTRL_RUN   2
`define WRMS_CTRL_FSH   3
`define WRMS_CTRL_MIX   4
`define WRMS_CTRL_SYNC  5
`define WRMS_CTRL_SLAVE 6
`define WRMS_CTRL_SHAPE 9:7

// trigger, status and step fields
`define WRMS_TRIG_SOFT  0
`define WRMS_TRIG_JUMP  1
`define WRMS_CLR_LEN    0
`define WRMS_CLR_SEQ    1
`define WRMS_STEP_REP   15:0
`define WRMS_STEP_INF   16
`define WRMS_STEP_WAIT  17
`define WRMS_STEP_JMP   30:18

// limits
`define WRMS_STEPS      8000
`define WRMS_STEP_MAX   13'h1f40
`define WRMS_LEN_MIN    26'h00003c0
`define WRMS_LEN_STD    26'h1ee6280
`define WRMS_LEN_EXT    26'h3dcc500
`define WRMS_LEN_ALIGN  1:0
`define WRMS_FIFO_DEPTH 4

`endif

// *** pkg/wrms_pkg.sv ***
package wrms_pkg;

  typedef enum logic [1:0] {
    WRMS_CONT,
    WRMS_TRIG,
    WRMS_GATED,
    WRMS_ENH
  } wrms_mode_t;

  typedef enum logic [2:0] {
    WRMS_SINE,
    WRMS_TRI,
    WRMS_SQUARE,
    WRMS_RAMP,
    WRMS_PULSE,
    WRMS_DC
  } wrms_shape_t;

  typedef struct packed {
    logic [1:0] mk;
    logic [7:0] data;
  } wrms_sample_t;

  typedef struct packed {
    logic [25:0] base;
    logic [25:0] len;
    logic [15:0] rep;
    logic        inf;
    logic        wait_trig;
    logic [12:0] jump;
  } wrms_step_t;

endpackage

// *** hw/wrms_seq.sv ***
`timescale 1ns/100ps
`include "wrms_cfg.svh"

// small sample fifo with honest full and empty
module wrms_fifo #(
  parameter int W = 10,
  parameter int D = 4
) (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   flush,
  input  wire logic                   in_valid,
  input  wire logic [W-1:0]           in_data,
  output logic                        in_ready,
  output logic                        out_valid,
  output logic [W-1:0]                out_data,
  input  wire logic                   out_ready,
  output logic [$clog2(D):0]          level
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_q [D];
  logic [AW:0]  wp_q;
  logic [AW:0]  rp_q;
  logic         push;
  logic         pop;

  // occupancy and handshakes
  assign level     = wp_q - rp_q;
  assign in_ready  = level != (AW+1)'(D);
  assign out_valid = level != '0;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_data  = mem_q[rp_q[AW-1:0]];

  // pointers
  always_ff @(posedge clk) begin
    if (rst || flush) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
    end
  end

  // storage
  always_ff @(posedge clk) begin
    if (push) mem_q[wp_q[AW-1:0]] <= in_data;
  end
endmodule

// Overview of operation
// - continuous: endless ordered steps, no triggers/jumps
// - triggered: one waveform per trigger, no jumps
// - trigger from pin, remote command, key
// - gated: continuous only while gate open
// - each gate opening restarts at first sample
// - clock output runs even with gate closed
// - enhanced: trigger waits and event jumps active
// - synchronous operation blocks event/software jumps
// - step repeat 1 to 65536 or infinite
// - length multiple of 4, 960..32400000
// - extended memory raises limit to 64800000
// - 8-bit sample plus two marker bits
// - function shapes or stored waveforms
// - digital mixing of two signals
// - master and slave synchronous roles
module wrms_seq (
  input  wire logic               core_clk,
  input  wire logic               sys_rst,
  input  wire logic [3:0]         reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic [31:0]             reg_rdata,
  input  wire logic               ext_trig,
  input  wire logic               trig_key,
  input  wire logic               event_in,
  input  wire logic               gate_in,
  input  wire logic               extended_memory_option,
  input  wire logic               sync_in,
  output logic                    sync_out,
  output logic                    clk_out,
  output logic [25:0]             mem_addr,
  output logic                    mem_rd,
  input  wire wrms_pkg::wrms_sample_t mem_data,
  output logic                    dac_valid,
  output wrms_pkg::wrms_sample_t  dac_sample,
  input  wire logic               dac_ready
);
  typedef enum {WRMS_IDLE, WRMS_WAIT, WRMS_PLAY} wrms_state_t;

  // limit check for one waveform length
  function automatic logic len_ok(input logic [25:0] len, input logic ext);
    len_ok = (len[`WRMS_LEN_ALIGN] == 2'h0) && (len >= `WRMS_LEN_MIN) &&
             (len <= (ext ? `WRMS_LEN_EXT : `WRMS_LEN_STD));
  endfunction

  // step index after s in a table of n steps
  function automatic logic [12:0] next_step(input logic [12:0] s, input logic [12:0] n);
    next_step = (s + 13'h1 >= n) ? 13'h0 : s + 13'h1;
  endfunction

  // one sample of the selected standard shape
  function automatic logic [7:0] shape_val(input wrms_pkg::wrms_shape_t sh,
                                           input logic [15:0] ph,
                                           input logic [7:0] lvl);
    logic [6:0]  p;
    logic [13:0] sq;
    p  = ph[14:8];
    sq = 14'(p) * 14'(7'h7f - p);
    case (sh)
      wrms_pkg::WRMS_SINE:   shape_val = ph[15] ? 8'h80 - 8'(sq[13:5]) : 8'h80 + 8'(sq[13:5]);
      wrms_pkg::WRMS_TRI:    shape_val = ph[15] ? {~p, 1'b0} : {p, 1'b0};
      wrms_pkg::WRMS_SQUARE: shape_val = ph[15] ? 8'h00 : 8'hff;
      wrms_pkg::WRMS_RAMP:   shape_val = ph[15:8];
      wrms_pkg::WRMS_PULSE:  shape_val = (ph[15:8] < lvl) ? 8'hff : 8'h00;
      default:               shape_val = lvl;
    endcase
  endfunction

  // software registers
  wrms_pkg::wrms_mode_t  mode_q;
  wrms_pkg::wrms_shape_t shape_q;
  logic        run_q;
  logic        fsh_q;
  logic        mix_q;
  logic        sync_q;
  logic        slave_q;
  logic [15:0] freq_q;
  logic [7:0]  level_q;
  logic [12:0] seq_len_q;
  logic [12:0] sel_q;
  logic [25:0] base_q;
  logic [25:0] len_q;
  logic        err_len_q;
  logic        err_seq_q;
  logic        ext_q;
  logic [31:0] rdata_q;
  wrms_pkg::wrms_step_t seq_mem [`WRMS_STEPS];

  // playback state
  wrms_state_t st_q;
  wrms_state_t st_d;
  logic [12:0] step_q;
  logic [12:0] step_d;
  logic [25:0] off_q;
  logic [25:0] off_d;
  logic [15:0] rep_q;
  logic [15:0] rep_d;
  logic        rd_d;
  logic        restart;
  logic        rd_q;
  logic        pend_q;
  logic        drop_q;
  logic [25:0] addr_q;
  logic [15:0] phase_q;
  logic        trig_prev_q;
  logic        key_prev_q;
  logic        evt_prev_q;
  logic        gate_prev_q;
  logic        sync_prev_q;
  logic        sync_out_q;
  logic        clk_div_q;
  logic        dac_valid_q;
  wrms_pkg::wrms_sample_t dac_q;

  // bus decode
  wire wr_ctrl   = reg_wr && reg_addr == `WRMS_A_CTRL;
  wire wr_status = reg_wr && reg_addr == `WRMS_A_STATUS;
  wire wr_trig   = reg_wr && reg_addr == `WRMS_A_TRIG;
  wire wr_seqlen = reg_wr && reg_addr == `WRMS_A_SEQLEN;
  wire wr_sel    = reg_wr && reg_addr == `WRMS_A_SEL;
  wire wr_base   = reg_wr && reg_addr == `WRMS_A_BASE;
  wire wr_len    = reg_wr && reg_addr == `WRMS_A_LEN;
  wire wr_step   = reg_wr && reg_addr == `WRMS_A_STEP;
  wire wr_freq   = reg_wr && reg_addr == `WRMS_A_FREQ;
  wire wr_level  = reg_wr && reg_addr == `WRMS_A_LEVEL;

  // write validity checks
  wire [12:0] new_len  = reg_wdata[12:0];
  wire        seq_ok   = new_len != 13'h0 && new_len <= `WRMS_STEP_MAX;
  wire        step_ok  = len_ok(len_q, ext_q) && sel_q < `WRMS_STEP_MAX;
  wire        set_len  = wr_step && !step_ok;
  wire        set_seq  = wr_seqlen && !seq_ok;
  wire        step_wen = wr_step && step_ok;

  // trigger and jump events
  wire soft_trig = wr_trig && reg_wdata[`WRMS_TRIG_SOFT];
  wire soft_jump = wr_trig && reg_wdata[`WRMS_TRIG_JUMP];
  wire sync_rise = slave_q && sync_q && sync_in && !sync_prev_q;
  wire trig_evt  = (ext_trig && !trig_prev_q) || (trig_key && !key_prev_q) ||
                   soft_trig || sync_rise;
  wire jump_evt  = ((event_in && !evt_prev_q) || soft_jump) &&
                   mode_q == wrms_pkg::WRMS_ENH && !sync_q && st_q != WRMS_IDLE;
  wire gate_rise = mode_q == wrms_pkg::WRMS_GATED && gate_in && !gate_prev_q;
  wire gate_ok   = mode_q != wrms_pkg::WRMS_GATED || gate_in;

  // current, next and jump-target steps
  wrms_pkg::wrms_step_t cur;
  wrms_pkg::wrms_step_t nxt;
  wrms_pkg::wrms_step_t jmp;
  wrms_pkg::wrms_step_t first;
  wire [12:0] nxt_idx = next_step(step_q, seq_len_q);
  assign cur   = seq_mem[step_q];
  assign nxt   = seq_mem[nxt_idx];
  assign jmp   = seq_mem[cur.jump];
  assign first = seq_mem[13'h0];

  // fifo credit and sample sources
  logic [2:0]             fifo_level;
  logic                   fifo_in_ready;
  logic                   fifo_out_valid;
  wrms_pkg::wrms_sample_t fifo_out;
  wrms_pkg::wrms_sample_t push_data;
  wire        room     = 3'(fifo_level) + 3'(rd_q) + 3'(pend_q) < 3'(`WRMS_FIFO_DEPTH);
  wire        playing  = st_q == WRMS_PLAY && gate_ok && run_q;
  wire        adv      = playing && !fsh_q && room;
  wire        flush    = restart || !gate_ok;
  wire [7:0]  shp      = shape_val(shape_q, phase_q, level_q);
  wire [8:0]  mix_sum  = 9'(mem_data.data) + 9'(shp);
  wire        push_mem = pend_q && !drop_q;
  wire        push_fsh = fsh_q && playing && fifo_in_ready && !flush;
  wire        fifo_pop = !dac_valid_q || dac_ready;

  // sample selection: stored, mixed or generated
  always_comb begin
    push_data = mem_data;
    if (fsh_q) begin
      push_data.mk   = 2'h0;
      push_data.data = shp;
    end else if (mix_q) begin
      push_data.data = mix_sum[8:1];
    end
  end

  // playback sequencing
  always_comb begin
    st_d    = st_q;
    step_d  = step_q;
    off_d   = off_q;
    rep_d   = rep_q;
    rd_d    = 1'b0;
    restart = 1'b0;
    case (st_q)
      WRMS_IDLE: begin
        if (run_q) begin
          step_d  = 13'h0;
          off_d   = 26'h0;
          rep_d   = first.rep;
          restart = 1'b1;
          st_d    = (mode_q == wrms_pkg::WRMS_TRIG ||
                     (mode_q == wrms_pkg::WRMS_ENH && first.wait_trig)) ? WRMS_WAIT : WRMS_PLAY;
        end
      end
      WRMS_WAIT: begin
        if (trig_evt) st_d = WRMS_PLAY;
      end
      WRMS_PLAY: begin
        if (adv) begin
          rd_d = 1'b1;
          if (off_q == cur.len - 26'h1) begin
            off_d = 26'h0;
            if (mode_q == wrms_pkg::WRMS_TRIG) begin
              st_d = WRMS_WAIT;
            end else if (!cur.inf && rep_q == 16'h0) begin
              step_d = nxt_idx;
              rep_d  = nxt.rep;
              if (mode_q == wrms_pkg::WRMS_ENH && nxt.wait_trig) st_d = WRMS_WAIT;
            end else if (!cur.inf) begin
              rep_d = rep_q - 16'h1;
            end
          end else begin
            off_d = off_q + 26'h1;
          end
        end
      end
      default: st_d = WRMS_IDLE;
    endcase
    if (jump_evt) begin
      step_d  = cur.jump;
      off_d   = 26'h0;
      rep_d   = jmp.rep;
      rd_d    = 1'b0;
      restart = 1'b1;
      st_d    = WRMS_PLAY;
    end
    if (gate_rise) begin
      step_d  = 13'h0;
      off_d   = 26'h0;
      rep_d   = first.rep;
      rd_d    = 1'b0;
      restart = 1'b1;
      st_d    = WRMS_PLAY;
    end
    if (!run_q) begin
      st_d    = WRMS_IDLE;
      rd_d    = 1'b0;
      restart = st_q != WRMS_IDLE;
    end
  end

  // control register writes
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mode_q  <= wrms_pkg::WRMS_CONT;
      shape_q <= wrms_pkg::WRMS_SINE;
      run_q   <= 1'b0;
      fsh_q   <= 1'b0;
      mix_q   <= 1'b0;
      sync_q  <= 1'b0;
      slave_q <= 1'b0;
    end else if (wr_ctrl) begin
      mode_q  <= wrms_pkg::wrms_mode_t'(reg_wdata[`WRMS_CTRL_MODE]);
      shape_q <= wrms_pkg::wrms_shape_t'(reg_wdata[`WRMS_CTRL_SHAPE]);
      run_q   <= reg_wdata[`WRMS_CTRL_RUN];
      fsh_q   <= reg_wdata[`WRMS_CTRL_FSH];
      mix_q   <= reg_wdata[`WRMS_CTRL_MIX];
      sync_q  <= reg_wdata[`WRMS_CTRL_SYNC];
      slave_q <= reg_wdata[`WRMS_CTRL_SLAVE];
    end
  end

  // setup registers and option strap
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      freq_q    <= 16'h0100;
      level_q   <= 8'h80;
      seq_len_q <= 13'h1;
      sel_q     <= 13'h0;
      base_q    <= 26'h0;
      len_q     <= `WRMS_LEN_MIN;
      ext_q     <= extended_memory_option;
    end else begin
      if (wr_freq) freq_q <= reg_wdata[15:0];
      if (wr_level) level_q <= reg_wdata[7:0];
      if (wr_seqlen && seq_ok) seq_len_q <= new_len;
      if (wr_sel) sel_q <= reg_wdata[12:0];
      if (wr_base) base_q <= reg_wdata[25:0];
      if (wr_len) len_q <= reg_wdata[25:0];
    end
  end

  // sticky errors, a new error beats the clear
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      err_len_q <= 1'b0;
      err_seq_q <= 1'b0;
    end else begin
      err_len_q <= set_len || (err_len_q && !(wr_status && reg_wdata[`WRMS_CLR_LEN]));
      err_seq_q <= set_seq || (err_seq_q && !(wr_status && reg_wdata[`WRMS_CLR_SEQ]));
    end
  end

  // step table, committed by the step control write
  always_ff @(posedge core_clk) begin
    if (step_wen) seq_mem[sel_q] <= '{base: base_q, len: len_q,
                                      rep: reg_wdata[`WRMS_STEP_REP],
                                      inf: reg_wdata[`WRMS_STEP_INF],
                                      wait_trig: reg_wdata[`WRMS_STEP_WAIT],
                                      jump: reg_wdata[`WRMS_STEP_JMP]};
  end

  // register read, valid one cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (sys_rst || !reg_rd) begin
      rdata_q <= 32'h0;
    end else begin
      case (reg_addr)
        `WRMS_A_CTRL:   rdata_q <= {22'h0, shape_q, slave_q, sync_q, mix_q, fsh_q, run_q, mode_q};
        `WRMS_A_STATUS: rdata_q <= {11'h0, ext_q, err_seq_q, err_len_q,
                                    st_q == WRMS_WAIT, st_q == WRMS_PLAY, 3'h0, step_q};
        `WRMS_A_SEQLEN: rdata_q <= {19'h0, seq_len_q};
        `WRMS_A_SEL:    rdata_q <= {19'h0, sel_q};
        `WRMS_A_BASE:   rdata_q <= {6'h0, base_q};
        `WRMS_A_LEN:    rdata_q <= {6'h0, len_q};
        `WRMS_A_FREQ:   rdata_q <= {16'h0, freq_q};
        `WRMS_A_LEVEL:  rdata_q <= {24'h0, level_q};
        default:        rdata_q <= 32'h0;
      endcase
    end
  end

  // sequencer state
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_q   <= WRMS_IDLE;
      step_q <= 13'h0;
      off_q  <= 26'h0;
      rep_q  <= 16'h0;
    end else begin
      st_q   <= st_d;
      step_q <= step_d;
      off_q  <= off_d;
      rep_q  <= rep_d;
    end
  end

  // memory fetch pipeline, stale words dropped after a restart
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rd_q   <= 1'b0;
      pend_q <= 1'b0;
      drop_q <= 1'b0;
      addr_q <= 26'h0;
    end else begin
      rd_q   <= rd_d;
      pend_q <= rd_q;
      drop_q <= flush && rd_q;
      if (rd_d) addr_q <= cur.base + off_q;
    end
  end

  // edge history and shape phase
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      trig_prev_q <= 1'b0;
      key_prev_q  <= 1'b0;
      evt_prev_q  <= 1'b0;
      gate_prev_q <= 1'b0;
      sync_prev_q <= 1'b0;
      phase_q     <= 16'h0;
    end else begin
      trig_prev_q <= ext_trig;
      key_prev_q  <= trig_key;
      evt_prev_q  <= event_in;
      gate_prev_q <= gate_in;
      sync_prev_q <= sync_in;
      if (restart) phase_q <= 16'h0;
      else if (push_fsh || (mix_q && push_mem)) phase_q <= phase_q + freq_q;
    end
  end

  // master start pulse and free-running clock output
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sync_out_q <= 1'b0;
      clk_div_q  <= 1'b0;
    end else begin
      sync_out_q <= sync_q && !slave_q && (trig_evt || restart);
      clk_div_q  <= !clk_div_q;
    end
  end

  wrms_fifo #(.W($bits(wrms_pkg::wrms_sample_t)), .D(`WRMS_FIFO_DEPTH)) u_fifo (
    .clk       (core_clk),
    .rst       (sys_rst),
    .flush     (flush),
    .in_valid  (push_mem || push_fsh),
    .in_data   (push_data),
    .in_ready  (fifo_in_ready),
    .out_valid (fifo_out_valid),
    .out_data  (fifo_out),
    .out_ready (fifo_pop),
    .level     (fifo_level)
  );

  // converter output stage
  always_ff @(posedge core_clk) begin
    if (sys_rst || flush) begin
      dac_valid_q <= 1'b0;
      dac_q       <= '0;
    end else if (fifo_pop) begin
      dac_valid_q <= fifo_out_valid;
      dac_q       <= fifo_out;
    end
  end

  assign reg_rdata  = rdata_q;
  assign sync_out   = sync_out_q;
  assign clk_out    = clk_div_q;
  assign mem_addr   = addr_q;
  assign mem_rd     = rd_q;
  assign dac_valid  = dac_valid_q;
  assign dac_sample = dac_q;
endmodule

// *** verif/wrms_seq_sva.sv ***
`timescale 1ns/100ps
`include "wrms_cfg.svh"

// port-level checks on the playback sequencer
module wrms_seq_sva (
  input wire logic                   core_clk,
  input wire logic                   sys_rst,
  input wire logic [3:0]             reg_addr,
  input wire logic                   reg_rd,
  input wire logic [31:0]            reg_rdata,
  input wire logic                   extended_memory_option,
  input wire logic                   sync_out,
  input wire logic                   clk_out,
  input wire logic                   dac_valid,
  input wire wrms_pkg::wrms_sample_t dac_sample,
  input wire logic                   dac_ready
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  // clock output and output stream
  clk_free_run_a: assert property (!$past(sys_rst) |-> clk_out != $past(clk_out))
    else $error("clock output did not toggle");
  stall_hold_a: assert property (dac_valid && !dac_ready |=> dac_valid && $stable(dac_sample))
    else $error("sample changed during stall");
  sync_pulse_a: assert property (sync_out |=> !sync_out)
    else $error("sync pulse longer than one cycle");
  // register read path
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read slot");
  unmapped_zero_a: assert property ($past(reg_rd) && $past(reg_addr) > `WRMS_A_LEVEL
    |-> reg_rdata == 32'h0)
    else $error("unmapped read not zero");
  step_write_only_a: assert property ($past(reg_rd) && $past(reg_addr) == `WRMS_A_STEP
    |-> reg_rdata == 32'h0)
    else $error("step register readable");
  strap_status_a: assert property ($past(reg_rd) && $past(reg_addr) == `WRMS_A_STATUS
    |-> reg_rdata[20] == extended_memory_option)
    else $error("strap bit wrong in status");
  seq_len_range_a: assert property ($past(reg_rd) && $past(reg_addr) == `WRMS_A_SEQLEN
    |-> reg_rdata[12:0] != 13'h0 && reg_rdata[12:0] <= `WRMS_STEP_MAX)
    else $error("sequence length out of range");
  step_idx_range_a: assert property ($past(reg_rd) && $past(reg_addr) == `WRMS_A_STATUS
    |-> reg_rdata[12:0] < `WRMS_STEP_MAX)
    else $error("step index out of range");
endmodule

bind wrms_seq wrms_seq_sva chk (
  .core_clk(core_clk),
  .sys_rst(sys_rst),
  .reg_addr(reg_addr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .extended_memory_option(extended_memory_option),
  .sync_out(sync_out),
  .clk_out(clk_out),
  .dac_valid(dac_valid),
  .dac_sample(dac_sample),
  .dac_ready(dac_ready)
);

// *** verif/wrms_dac_model.sv ***
`timescale 1ns/100ps

// converter-side sink, stalls two of four cycles when asked
module wrms_dac_model (
  input  wire logic                   clk,
  input  wire logic                   stall_en,
  input  wire logic                   valid,
  input  wire wrms_pkg::wrms_sample_t sample,
  output logic                        ready
);
  wrms_pkg::wrms_sample_t seen[$];
  logic [1:0]             ph = 2'h0;
  initial ready = 1'b0;
  // accept and record one word per handshake
  always @(posedge clk) begin
    ph <= ph + 2'h1;
    ready <= !stall_en || ph[1];
    if (valid && ready)
      seen.push_back(sample);
  end
endmodule

// *** verif/waveform_run_mode_sequencer_test.sv ***
`timescale 1ns/100ps
`include "wrms_cfg.svh"
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR %s expected %h seen %h", n, e, g); end end

module waveform_run_mode_sequencer_test;
  logic                   core_clk = 1'b0;
  logic                   sys_rst = 1'b1;
  logic [3:0]             reg_addr = 4'h0;
  logic [31:0]            reg_wdata = 32'h0;
  logic [31:0]            reg_rdata;
  logic                   reg_wr = 1'b0, reg_rd = 1'b0, gate_in = 1'b0, stall_en = 1'b0;
  logic                   ext_trig = 1'b0, trig_key = 1'b0, event_in = 1'b0, sync_in = 1'b0;
  logic                   extended_memory_option = 1'b0;
  logic                   sync_out, clk_out, mem_rd, dac_valid, dac_ready;
  logic [25:0]            mem_addr;
  wrms_pkg::wrms_sample_t mem_data = 10'h0, dac_sample;
  int                     mismatches = 0, checks = 0, cyc = 0, sync_cnt = 0;

  wrms_seq dut (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_trig(ext_trig), .trig_key(trig_key), .event_in(event_in), .gate_in(gate_in),
    .extended_memory_option(extended_memory_option), .sync_in(sync_in),
    .sync_out(sync_out), .clk_out(clk_out), .mem_addr(mem_addr), .mem_rd(mem_rd),
    .mem_data(mem_data), .dac_valid(dac_valid), .dac_sample(dac_sample),
    .dac_ready(dac_ready));
  wrms_dac_model dac_m (.clk(core_clk), .stall_en(stall_en), .valid(dac_valid),
    .sample(dac_sample), .ready(dac_ready));

  always #12.5 core_clk = ~core_clk;
  // memory answers next cycle, sync pulses counted
  always @(posedge core_clk) begin
    mem_data <= mem_rd ? wrms_pkg::wrms_sample_t'(mem_addr[9:0]) : ~mem_data;
    sync_cnt += int'(sync_out === 1'b1);
    cyc++;
    if (cyc == 60000) begin
      mismatches++;
      results();
    end
  end

  function automatic wrms_pkg::wrms_sample_t smp(input logic [25:0] a);
    return a[9:0];
  endfunction
  function automatic logic [31:0] ctl(input wrms_pkg::wrms_mode_t m, input logic [6:0] x);
    return {22'h0, x, 1'b1, m};
  endfunction
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  task automatic step(input logic [12:0] i, input logic [25:0] b, input logic [31:0] s);
    wr(`WRMS_A_SEL, {19'h0, i});
    wr(`WRMS_A_BASE, {6'h0, b});
    wr(`WRMS_A_LEN, {6'h0, `WRMS_LEN_MIN});
    wr(`WRMS_A_STEP, s);
  endtask
  task automatic stop();
    wr(`WRMS_A_CTRL, 32'h0);
    repeat (20) @(posedge core_clk);
    dac_m.seen.delete();
  endtask
  task automatic wait_n(input int n);
    for (int k = 0; k < 8 * n + 200 && dac_m.seen.size() < n; k++)
      @(posedge core_clk);
  endtask
  task automatic fire(input int s);
    @(posedge core_clk);
    case (s)
      0: ext_trig <= 1'b1;
      1: trig_key <= 1'b1;
      2: event_in <= 1'b1;
      default: sync_in <= 1'b1;
    endcase
    repeat (2) @(posedge core_clk);
    {ext_trig, trig_key, event_in, sync_in} <= 4'h0;
  endtask

  // reset values and sequence length limits
  task automatic t_regs();
    logic [31:0] v;
    logic [3:0]  a[7];
    logic [31:0] e[7];
    a = '{`WRMS_A_STATUS, `WRMS_A_SEQLEN, `WRMS_A_LEN, `WRMS_A_FREQ, `WRMS_A_LEVEL,
      `WRMS_A_STEP, 4'hf};
    e = '{32'h0, 32'h1, 32'h3c0, 32'h100, 32'h80, 32'h0, 32'h0};
    for (int i = 0; i < 7; i++) begin
      rd(a[i], v);
      `CHK("reset value", e[i], v)
    end
    wr(`WRMS_A_SEQLEN, 32'h0);
    wr(`WRMS_A_SEQLEN, 32'h1f41);
    rd(`WRMS_A_STATUS, v);
    `CHK("seq length refusal", 1'b1, v[19])
    wr(`WRMS_A_SEQLEN, 32'h1f40);
    rd(`WRMS_A_SEQLEN, v);
    `CHK("seq length max", 32'h1f40, v)
    wr(`WRMS_A_STATUS, 32'h2);
    rd(`WRMS_A_STATUS, v);
    `CHK("seq error clear", 1'b0, v[19])
  endtask
  // waveform length limits with and without the memory strap
  task automatic lens(input logic x);
    logic [31:0] v;
    logic [25:0] l[6];
    logic        e[6];
    l = '{26'h3c1, 26'h3bc, `WRMS_LEN_STD + 26'h4, `WRMS_LEN_EXT, `WRMS_LEN_EXT + 26'h4,
      26'h3c4};
    e = '{1'b1, 1'b1, !x, !x, 1'b1, 1'b0};
    for (int i = 0; i < 6; i++) begin
      wr(`WRMS_A_STATUS, 32'h1);
      wr(`WRMS_A_LEN, {6'h0, l[i]});
      wr(`WRMS_A_STEP, 32'h0);
      rd(`WRMS_A_STATUS, v);
      `CHK("length refusal", e[i], v[18])
    end
  endtask
  // step repeats, then next, wraps, under stalls
  task automatic t_cont();
    step(0, 26'h100, 32'h1);
    step(1, 26'h300, 32'h0);
    wr(`WRMS_A_SEQLEN, 32'h2);
    stall_en <= 1'b1;
    wr(`WRMS_A_CTRL, ctl(wrms_pkg::WRMS_CONT, 7'h0));
    fire(0);
    fire(2);
    wait_n(2885);
    for (int i = 0; i < 40; i++)
      `CHK("stream word", smp(26'h100 + 26'(i)), dac_m.seen[i])
    `CHK("step0 end", smp(26'h4bf), dac_m.seen[959])
    `CHK("step0 repeat", smp(26'h100), dac_m.seen[960])
    `CHK("step1 start", smp(26'h300), dac_m.seen[1920])
    `CHK("step1 end", smp(26'h6bf), dac_m.seen[2879])
    `CHK("sequence wrap", smp(26'h100), dac_m.seen[2880])
    stall_en <= 1'b0;
    stop();
  endtask
  // one pass per trigger, each source, master then slave
  task automatic t_trig();
    int n, p;
    step(0, 26'h200, 32'h0);
    wr(`WRMS_A_SEQLEN, 32'h1);
    wr(`WRMS_A_CTRL, ctl(wrms_pkg::WRMS_TRIG, 7'h04));
    repeat (100) @(posedge core_clk);
    `CHK("idle before trigger", 0, dac_m.seen.size())
    p = sync_cnt;
    for (int s = 0; s < 4; s++) begin
      if (s == 3)
        wr(`WRMS_A_CTRL, ctl(wrms_pkg::WRMS_TRIG, 7'h0c));
      n = dac_m.seen.size();
      if (s == 2)
        wr(`WRMS_A_TRIG, 32'h1);
      else
        fire(s);
      wait_n(n + 960);
      repeat (100) @(posedge core_clk);
      `CHK("one pass per trigger", n + 960, dac_m.seen.size())
      `CHK("pass start", smp(26'h200), dac_m.seen[n])
      if (s == 0)
        `CHK("master sync pulse", 1, sync_cnt - p)
    end
    stop();
  endtask
  // gate closed gives nothing, each opening restarts
  task automatic t_gate();
    int n;
    step(0, 26'h100, 32'h10000);
    wr(`WRMS_A_CTRL, ctl(wrms_pkg::WRMS_GATED, 7'h0));
    repeat (50) @(posedge core_clk);
    `CHK("gate closed idle", 0, dac_m.seen.size())
    gate_in <= 1'b1;
    wait_n(100);
    gate_in <= 1'b0;
    repeat (30) @(posedge core_clk);
    n = dac_m.seen.size();
    `CHK("gate first word", smp(26'h100), dac_m.seen[0])
    repeat (50) @(posedge core_clk);
    `CHK("no output gate closed", n, dac_m.seen.size())
    gate_in <= 1'b1;
    wait_n(n + 1);
    `CHK("gate restart", smp(26'h100), dac_m.seen[n])
    gate_in <= 1'b0;
    stop();
  endtask
  // event jump works in enhanced mode, blocked under sync
  task automatic t_jump();
    step(0, 26'h100, 32'h50000);
    step(1, 26'h300, 32'h50000);
    wr(`WRMS_A_SEQLEN, 32'h2);
    for (int y = 0; y < 2; y++) begin
      wr(`WRMS_A_CTRL, ctl(wrms_pkg::WRMS_ENH, y ? 7'h04 : 7'h00));
      wait_n(10);
      fire(2);
      wr(`WRMS_A_TRIG, 32'h2);
      repeat (50) @(posedge core_clk);
      `CHK("jump outcome", y ? 2'h1 : 2'h3, dac_m.seen[$].mk)
      stop();
    end
  endtask
  // every shape runs, dc level, then mixing with memory
  task automatic t_shape();
    wr(`WRMS_A_LEVEL, 32'h5a);
    for (int s = 0; s < 6; s++) begin
      wr(`WRMS_A_CTRL, ctl(wrms_pkg::WRMS_CONT, {3'(s), 4'h1}));
      wait_n(8);
      `CHK("shape output", 1'b1, dac_m.seen.size() >= 8)
      if (s == 5)
        `CHK("dc level", 8'h5a, dac_m.seen[7].data)
      stop();
    end
    step(0, 26'h100, 32'h10000);
    wr(`WRMS_A_SEQLEN, 32'h1);
    wr(`WRMS_A_CTRL, ctl(wrms_pkg::WRMS_CONT, 7'h52));
    wait_n(1);
    `CHK("mixed word", 10'h12d, dac_m.seen[0])
    stop();
  endtask

  task automatic results();
    if (mismatches == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // main sequence, ends with a strapped reset
  initial begin
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    t_regs();
    lens(1'b0);
    t_cont();
    t_trig();
    t_gate();
    t_jump();
    t_shape();
    sys_rst <= 1'b1;
    extended_memory_option <= 1'b1;
    repeat (10) @(posedge core_clk);
    sys_rst <= 1'b0;
    lens(1'b1);
    results();
  end
endmodule
